// ==== inc/plm_pkg.sv ====
`default_nettype none
package plm_pkg;
   // ==========================================================
   // array geometry
   localparam int PLM_NUM_MC = 8;
   localparam int PLM_NUM_PT = 8;
   localparam int PLM_NUM_IN = 8;
   localparam int PLM_NUM_COL = 16;
   localparam int PLM_PD_COL = 2;
   localparam int PLM_CENTRE_LO = 3;
   localparam int PLM_CENTRE_HI = 4;
   // ==========================================================
   // register map
   localparam int PLM_ADDR_W = 12;
   localparam logic [11:0] PLM_CFG_OFS = 12'h000;
   localparam logic [11:0] PLM_MCCFG_OFS = 12'h004;
   localparam logic [11:0] PLM_STAT_OFS = 12'h008;
   localparam logic [3:0] PLM_PT_PAGE = 4'h1;
   localparam int PLM_CFG_MODE_LSB = 0;
   localparam int PLM_CFG_PDEN_BIT = 2;
   localparam int PLM_MCCFG_W = 2;
   localparam logic [31:0] PLM_CFG_RST = 32'h0000_0000;
   // all macrocells start as inputs, so no pin drives out of reset
   localparam logic [31:0] PLM_MCCFG_RST = 32'h0000_AAAA;
   localparam logic [31:0] PLM_PT_RST = 32'h0000_0000;
   localparam logic [1:0] PLM_RESP_OKAY = 2'h0;
   localparam logic [1:0] PLM_RESP_SLVERR = 2'h2;
   // ==========================================================
   // types
   typedef enum logic [1:0] {PLM_MODE_REG, PLM_MODE_CPLX, PLM_MODE_SIMPLE} plm_mode_e;
   typedef enum logic [1:0] {PLM_MC_REG, PLM_MC_COMB, PLM_MC_INPUT} plm_mc_e;
endpackage : plm_pkg
`default_nettype wire

// ==== rtl/plm_macrocell.sv ====
`timescale 1ns/100ps
`default_nettype none
module plm_macrocell
   import plm_pkg::*;
#(
   parameter int NUM_PT = PLM_NUM_PT,
   parameter bit CENTRE = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [NUM_PT-1:0] pt_i,
   input wire plm_mode_e mode_i,
   input wire plm_mc_e mc_i,
   input wire logic oe_pin_n_i,
   input wire logic capture_i,
   output logic data_o,
   output logic oe_o,
   output logic q_o
);
   // ==========================================================
   // sum terms
   logic sum_all;
   logic sum_low;
   logic q_d;
   logic q_q;
   assign sum_all = |pt_i;
   assign sum_low = |pt_i[NUM_PT-1:1];
   assign q_o = q_q;

   // ==========================================================
   // output selection
   always_comb begin
      data_o = 1'b0;
      oe_o = 1'b0;
      unique case (mode_i)
         PLM_MODE_REG: begin
            if (mc_i == PLM_MC_REG) begin
               data_o = q_q;
               oe_o = ~oe_pin_n_i;
            end else if (mc_i == PLM_MC_COMB) begin
               data_o = sum_low;
               oe_o = pt_i[0];
            end
         end
         PLM_MODE_CPLX: begin
            data_o = sum_low;
            oe_o = (mc_i == PLM_MC_INPUT) ? 1'b0 : pt_i[0];
         end
         PLM_MODE_SIMPLE: begin
            data_o = sum_all;
            oe_o = CENTRE || (mc_i != PLM_MC_INPUT);
         end
         default: begin
            data_o = 1'b0;
            oe_o = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // register
   // eight terms captured
   always_comb begin
      q_d = capture_i ? sum_all : q_q;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_q <= 1'b0;
      end else begin
         q_q <= q_d;
      end
   end

   a_reg_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      capture_i |=> (q_o == $past(|pt_i)))
      else $error("register missed its capture");
   a_reg_hold_q: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !capture_i |=> $stable(q_o))
      else $error("register changed without clock edge");
endmodule : plm_macrocell
`default_nettype wire

// ==== rtl/plm_macrocell_array.sv ====
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - registered mode: each cell registered, combinatorial, or input.
// - registered cells clock on clock pin, enable from enable pin.
// - registered cell sums all eight product terms.
// - registered-mode combinatorial cell: one term enables, seven summed.
// - a cell set as input never drives its pin, except a centre cell in simple mode.
// - registered mode: clock and enable pins are not array inputs.
// - complex and simple modes: those two pins feed the array.
// - complex mode: six inner cells feed pin levels back.
// - complex mode: two outer cells give no feedback.
// - complex mode: seven terms summed, one term enables.
// - simple mode: eight terms summed, no enable term.
// - simple mode: two centre cells always combinatorial outputs.
// - simple mode: centre cells always drive.
// - simple mode: other cells are inputs or outputs with feedback.
// - power-down option removes the power-down pin from the array.
// - simple mode: pin feedback goes through the neighbour's path.
// - during power-down outputs and registers hold, array columns still follow the inputs.
module plm_macrocell_array
   import plm_pkg::*;
#(
   parameter int NUM_MC = PLM_NUM_MC,
   parameter int NUM_IN = PLM_NUM_IN
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic clk_pin_i,
   input wire logic oe_pin_n_i,
   input wire logic [NUM_IN-1:0] in_pin_i,
   input wire logic [NUM_MC-1:0] io_pin_i,
   output logic [NUM_MC-1:0] io_pin_o,
   output logic [NUM_MC-1:0] io_pin_oe_o
);
   localparam int NUM_PTW = NUM_MC * PLM_NUM_PT;

   // ==========================================================
   // pin synchronisers
   logic [NUM_IN+NUM_MC+1:0] sync1_q;
   logic [NUM_IN+NUM_MC+1:0] sync2_q;
   logic clk_dly_q;
   logic [NUM_IN-1:0] in_s;
   logic [NUM_MC-1:0] io_s;
   logic clk_s;
   logic oe_n_s;
   assign {clk_s, oe_n_s, io_s, in_s} = sync2_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         clk_dly_q <= 1'b0;
      end else begin
         sync1_q <= {clk_pin_i, oe_pin_n_i, io_pin_i, in_pin_i};
         sync2_q <= sync1_q;
         clk_dly_q <= clk_s;
      end
   end

   // ==========================================================
   // configuration registers
   logic [31:0] cfg_q;
   logic [31:0] cfg_d;
   logic [31:0] mccfg_q;
   logic [31:0] mccfg_d;
   logic [31:0] pt_q [NUM_PTW];
   logic [31:0] pt_d [NUM_PTW];
   plm_mode_e mode;
   logic pd_en;
   logic pd_hold;
   assign mode = plm_mode_e'(cfg_q[PLM_CFG_MODE_LSB +: 2]);
   assign pd_en = cfg_q[PLM_CFG_PDEN_BIT];
   assign pd_hold = pd_en && in_s[PLM_PD_COL];

   // ==========================================================
   // bus slave
   logic aw_have_q;
   logic aw_have_d;
   logic w_have_q;
   logic w_have_d;
   logic [11:0] awaddr_q;
   logic [11:0] awaddr_d;
   logic [31:0] wdata_q;
   logic [31:0] wdata_d;
   logic [3:0] wstrb_q;
   logic [3:0] wstrb_d;
   logic bvalid_q;
   logic bvalid_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;
   logic rvalid_q;
   logic rvalid_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [NUM_MC-1:0] q_all;
   logic [31:0] merged;
   logic [31:0] old_word;
   logic wr_go;

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      cfg_d = cfg_q;
      mccfg_d = mccfg_q;
      pt_d = pt_q;
      old_word = 32'h0000_0000;
      merged = 32'h0000_0000;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (wr_go) begin
         if (awaddr_q[11:8] == PLM_PT_PAGE) begin
            old_word = pt_q[awaddr_q[7:2]];
         end else if (awaddr_q[11:2] == PLM_CFG_OFS[11:2]) begin
            old_word = cfg_q;
         end else if (awaddr_q[11:2] == PLM_MCCFG_OFS[11:2]) begin
            old_word = mccfg_q;
         end
         for (int b = 0; b < 4; b++) begin
            merged[8*b +: 8] = wstrb_q[b] ? wdata_q[8*b +: 8] : old_word[8*b +: 8];
         end
         bresp_d = PLM_RESP_OKAY;
         if (awaddr_q[11:8] == PLM_PT_PAGE) begin
            pt_d[awaddr_q[7:2]] = merged;
         end else if (awaddr_q[11:2] == PLM_CFG_OFS[11:2]) begin
            cfg_d = merged;
         end else if (awaddr_q[11:2] == PLM_MCCFG_OFS[11:2]) begin
            mccfg_d = merged;
         end else if (awaddr_q[11:2] != PLM_STAT_OFS[11:2]) begin
            bresp_d = PLM_RESP_SLVERR;
         end
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d = PLM_RESP_OKAY;
         rdata_d = 32'h0000_0000;
         if (s_axi_araddr[11:8] == PLM_PT_PAGE) begin
            rdata_d = pt_q[s_axi_araddr[7:2]];
         end else if (s_axi_araddr[11:2] == PLM_CFG_OFS[11:2]) begin
            rdata_d = cfg_q;
         end else if (s_axi_araddr[11:2] == PLM_MCCFG_OFS[11:2]) begin
            rdata_d = mccfg_q;
         end else if (s_axi_araddr[11:2] == PLM_STAT_OFS[11:2]) begin
            rdata_d = {15'h0000, pd_hold, q_all, io_s};
         end else begin
            rresp_d = PLM_RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= PLM_RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= PLM_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         cfg_q <= PLM_CFG_RST;
         mccfg_q <= PLM_MCCFG_RST;
         for (int i = 0; i < NUM_PTW; i++) begin
            pt_q[i] <= PLM_PT_RST;
         end
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         cfg_q <= cfg_d;
         mccfg_q <= mccfg_d;
         pt_q <= pt_d;
      end
   end

   // ==========================================================
   // array columns
   logic [PLM_NUM_COL-1:0] cols;
   logic [NUM_PTW-1:0] pt_val;
   plm_mc_e mc_cfg [NUM_MC];

   always_comb begin
      cols = '0;
      cols[NUM_IN-1:0] = in_s;
      if (pd_en) begin
         cols[PLM_PD_COL] = 1'b0;
      end
      for (int k = 0; k < NUM_MC; k++) begin
         unique case (mode)
            PLM_MODE_REG: begin
               // clock and enable pins kept out
               cols[NUM_IN+k] = (mc_cfg[k] == PLM_MC_REG) ? q_all[k] : io_s[k];
            end
            PLM_MODE_CPLX: begin
               cols[NUM_IN+k] = io_s[k];
               // clock and enable pins as inputs
               if (k == 0) begin
                  cols[NUM_IN+k] = clk_s;
               end else if (k == NUM_MC-1) begin
                  cols[NUM_IN+k] = oe_n_s;
               end
            end
            PLM_MODE_SIMPLE: begin
               if (k == 0) begin
                  cols[NUM_IN+k] = clk_s;
               end else if (k == NUM_MC-1) begin
                  cols[NUM_IN+k] = oe_n_s;
               end else if (k < PLM_CENTRE_HI) begin
                  cols[NUM_IN+k] = io_s[k-1];
               end else begin
                  cols[NUM_IN+k] = io_s[k+1];
               end
            end
            default: begin
               cols[NUM_IN+k] = 1'b0;
            end
         endcase
      end
   end

   // unused terms read zero: an empty selection disables the term
   always_comb begin
      for (int t = 0; t < NUM_PTW; t++) begin
         pt_val[t] = (pt_q[t] != 32'h0000_0000);
         for (int c = 0; c < PLM_NUM_COL; c++) begin
            if ((pt_q[t][2*c] && !cols[c]) || (pt_q[t][2*c+1] && cols[c])) begin
               pt_val[t] = 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // macrocells and output hold
   logic [NUM_MC-1:0] data_all;
   logic [NUM_MC-1:0] oe_all;
   logic [NUM_MC-1:0] io_o_q;
   logic [NUM_MC-1:0] io_o_d;
   logic [NUM_MC-1:0] io_oe_q;
   logic [NUM_MC-1:0] io_oe_d;
   logic capture;
   assign capture = clk_s && !clk_dly_q && !pd_hold && (mode == PLM_MODE_REG);

   for (genvar k = 0; k < NUM_MC; k++) begin : g_mc
      localparam bit IS_CENTRE = (k == PLM_CENTRE_LO) || (k == PLM_CENTRE_HI);
      assign mc_cfg[k] = (mode == PLM_MODE_SIMPLE && IS_CENTRE) ? PLM_MC_COMB :
         (mode != PLM_MODE_REG && mccfg_q[2*k +: 2] == 2'h0) ? PLM_MC_COMB :
         plm_mc_e'(mccfg_q[2*k +: 2]);
      plm_macrocell #(
         .NUM_PT(PLM_NUM_PT),
         .CENTRE(IS_CENTRE)
      ) u_mc (
         .ref_clk_i(ref_clk_i),
         .rst_n_i(rst_n_i),
         .pt_i(pt_val[k*PLM_NUM_PT +: PLM_NUM_PT]),
         .mode_i(mode),
         .mc_i(mc_cfg[k]),
         .oe_pin_n_i(oe_n_s),
         .capture_i(capture),
         .data_o(data_all[k]),
         .oe_o(oe_all[k]),
         .q_o(q_all[k])
      );
   end

   always_comb begin
      io_o_d = pd_hold ? io_o_q : data_all;
      io_oe_d = pd_hold ? io_oe_q : oe_all;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_o_q <= '0;
         io_oe_q <= '0;
      end else begin
         io_o_q <= io_o_d;
         io_oe_q <= io_oe_d;
      end
   end
   assign io_pin_o = io_o_q;
   assign io_pin_oe_o = io_oe_q;

   // ==========================================================
   // checks
   logic [NUM_MC-1:0] in_mask;
   logic [NUM_MC-1:0] reg_mask;
   always_comb begin
      for (int k = 0; k < NUM_MC; k++) begin
         in_mask[k] = (mc_cfg[k] == PLM_MC_INPUT);
         reg_mask[k] = (mode == PLM_MODE_REG) && (mc_cfg[k] == PLM_MC_REG);
      end
   end

   a_input_oe_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !pd_hold |=> ((io_pin_oe_o & $past(in_mask)) == '0))
      else $error("input cell drives its pin");
   a_centre_always_on: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == PLM_MODE_SIMPLE && !pd_hold) |=>
      (io_pin_oe_o[PLM_CENTRE_LO] && io_pin_oe_o[PLM_CENTRE_HI]))
      else $error("centre cell not driving in simple mode");
   a_pd_out_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pd_hold |=> ($stable(io_pin_o) && $stable(io_pin_oe_o)))
      else $error("pins changed during power-down");
   a_reg_oe_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !pd_hold |=> ((io_pin_oe_o & $past(reg_mask)) == ($past(reg_mask) & {NUM_MC{!$past(oe_n_s)}})))
      else $error("registered cell enable not from enable pin");
   a_pd_col_removed: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pd_en |-> !cols[PLM_PD_COL])
      else $error("power-down pin reached the array");
   a_cplx_outer_cols: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == PLM_MODE_CPLX) |-> (cols[NUM_IN] == clk_s && cols[NUM_IN+NUM_MC-1] == oe_n_s))
      else $error("outer columns not fed by clock and enable pins");
   a_simple_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == PLM_MODE_SIMPLE) |-> (cols[NUM_IN+1] == io_s[0]))
      else $error("simple mode feedback not via neighbour");
   a_pd_no_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pd_hold |=> $stable(q_all))
      else $error("register changed during power-down");
   a_bresp_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write response dropped early");
endmodule : plm_macrocell_array
`default_nettype wire

// ==== verif/plm_board.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// board model: resolves each io pin from device and board drivers
module plm_board (
   input wire logic [7:0] io_pin_o,
   input wire logic [7:0] io_pin_oe_o,
   input wire logic [7:0] drv_en_i,
   input wire logic [7:0] drv_val_i,
   output logic [7:0] io_pin_i
);
   logic [7:0] keep_q = 8'h00;
   always @* begin
      for (int k = 0; k < 8; k++) begin
         // device wins; keeper holds the last level when nobody drives
         if (io_pin_oe_o[k]) begin
            keep_q[k] = io_pin_o[k];
         end else if (drv_en_i[k]) begin
            keep_q[k] = drv_val_i[k];
         end
      end
      io_pin_i = keep_q;
   end
endmodule : plm_board
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb
   import plm_pkg::*;
;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [1:0] bresp, rresp, resp;
   logic clk_pin_i = 1'b0, oe_pin_n_i = 1'b1;
   logic [7:0] in_pin_i = 8'h00, drv_en = 8'h00, drv_val = 8'h00;
   logic [7:0] io_pin_i, io_pin_o, io_pin_oe_o;
   logic [31:0] rd;
   int fail_count = 0, samples_checked = 0;
   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   plm_macrocell_array plm_macrocell_array_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .clk_pin_i(clk_pin_i), .oe_pin_n_i(oe_pin_n_i), .in_pin_i(in_pin_i),
      .io_pin_i(io_pin_i), .io_pin_o(io_pin_o), .io_pin_oe_o(io_pin_oe_o));
   plm_board plm_board_i (.io_pin_o(io_pin_o), .io_pin_oe_o(io_pin_oe_o), .drv_en_i(drv_en),
      .drv_val_i(drv_val), .io_pin_i(io_pin_i));
   // ==========================================================
   // shared tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd_reg(input logic [11:0] a);
      @(posedge ref_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd_reg
   task automatic pins(input logic [7:0] v);
      @(posedge ref_clk_i);
      in_pin_i <= v;
      repeat (8) @(posedge ref_clk_i);
   endtask : pins
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd_reg(PLM_CFG_OFS);
      chk("cfg reset", PLM_CFG_RST, rd);
      rd_reg(PLM_MCCFG_OFS);
      chk("mccfg reset", PLM_MCCFG_RST, rd);
      rd_reg(12'h00C);
      chk("unmapped rresp", {30'h0, PLM_RESP_SLVERR}, {30'h0, resp});
      wr(PLM_STAT_OFS, 32'hFFFF_FFFF);
      chk("status bresp", {30'h0, PLM_RESP_OKAY}, {30'h0, resp});
      wr(12'h00C, 32'h1);
      chk("unmapped bresp", {30'h0, PLM_RESP_SLVERR}, {30'h0, resp});
      chk("inputs undriven", 32'h0, {24'h0, io_pin_oe_o});
   endtask : t_reset
   task automatic t_registered();
      wr(PLM_CFG_OFS, 32'h0);
      wr(PLM_MCCFG_OFS, 32'h0000_AAA4);
      wr(12'h11C, 32'h1);
      wr(12'h120, 32'h4);
      wr(12'h13C, 32'h1);
      @(posedge ref_clk_i);
      oe_pin_n_i <= 1'b0;
      pins(8'h01);
      chk("comb oe off", 32'h0, {31'h0, io_pin_oe_o[1]});
      chk("comb data", 32'h1, {31'h0, io_pin_o[1]});
      @(posedge ref_clk_i);
      clk_pin_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      clk_pin_i <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      chk("reg data", 32'h1, {31'h0, io_pin_o[0]});
      chk("reg oe", 32'h1, {31'h0, io_pin_oe_o[0]});
      chk("input cells", 32'h0, {26'h0, io_pin_oe_o[7:2]});
      pins(8'h03);
      chk("comb oe on", 32'h1, {31'h0, io_pin_oe_o[1]});
      @(posedge ref_clk_i);
      oe_pin_n_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk("reg oe pin", 32'h0, {31'h0, io_pin_oe_o[0]});
   endtask : t_registered
   task automatic t_complex();
      wr(PLM_CFG_OFS, 32'h1);
      wr(PLM_MCCFG_OFS, 32'h0000_AA9A);
      wr(12'h140, 32'h4);
      wr(12'h144, 32'h0004_0000);
      @(posedge ref_clk_i);
      drv_en <= 8'h02;
      drv_val <= 8'h02;
      pins(8'h02);
      chk("cplx oe", 32'h1, {31'h0, io_pin_oe_o[2]});
      chk("fb high", 32'h1, {31'h0, io_pin_o[2]});
      @(posedge ref_clk_i);
      drv_val <= 8'h00;
      repeat (8) @(posedge ref_clk_i);
      chk("fb low", 32'h0, {31'h0, io_pin_o[2]});
      wr(12'h144, 32'h0001_0000);
      @(posedge ref_clk_i);
      clk_pin_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk("clk pin as input", 32'h1, {31'h0, io_pin_o[2]});
      // outer pin high, clock pin low: column must follow the clock pin
      clk_pin_i <= 1'b0;
      drv_en <= 8'h03;
      drv_val <= 8'h01;
      repeat (8) @(posedge ref_clk_i);
      chk("outer no feedback", 32'h0, {31'h0, io_pin_o[2]});
      drv_en <= 8'h00;
   endtask : t_complex
   task automatic t_simple_pd();
      wr(12'h144, 32'h0);
      wr(PLM_CFG_OFS, 32'h6);
      pins(8'h02);
      chk("simple sum", 32'h1, {31'h0, io_pin_o[2]});
      chk("centre oe", 32'h3, {30'h0, io_pin_oe_o[4:3]});
      pins(8'h06);
      pins(8'h04);
      chk("pd hold", 32'h1, {31'h0, io_pin_o[2]});
      chk("pd oe hold", 32'h1, {31'h0, io_pin_oe_o[2]});
      rd_reg(PLM_STAT_OFS);
      chk("pd status", 32'h1, {31'h0, rd[16]});
      pins(8'h00);
      chk("pd release", 32'h0, {31'h0, io_pin_o[2]});
      pins(8'h02);
      chk("no enable term", 32'h1, {31'h0, io_pin_oe_o[2]});
      // column 9 carries pin 0 in this mode, pin 1 in complex mode
      wr(12'h144, 32'h0004_0000);
      @(posedge ref_clk_i);
      drv_en <= 8'h01;
      drv_val <= 8'h01;
      pins(8'h00);
      chk("simple neighbour fb high", 32'h1, {31'h0, io_pin_o[2]});
      @(posedge ref_clk_i);
      drv_val <= 8'h00;
      repeat (8) @(posedge ref_clk_i);
      chk("simple neighbour fb low", 32'h0, {31'h0, io_pin_o[2]});
      drv_en <= 8'h00;
      // illegal mode code switches every output off
      wr(PLM_CFG_OFS, 32'h3);
      repeat (4) @(posedge ref_clk_i);
      chk("illegal mode oe", 32'h0, {24'h0, io_pin_oe_o});
   endtask : t_simple_pd
   // ==========================================================
   // run control
   task automatic close_out();
      $display("fail_count %0d samples_checked %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_registered();
      t_complex();
      t_simple_pd();
      close_out();
   end
endmodule : tb
`default_nettype wire
